// file: hdl/vdec_consts.vh
// Constants for the video decoder gain and mode control block
`ifndef VDEC_CONSTS_VH
`define VDEC_CONSTS_VH
// ****************************************
// Register sub-addresses
// ****************************************
`define SUB_PICTURE_OUTPUT 8'h01
`define SUB_CONTROL_ONE    8'h03
`define SUB_CONTROL_TWO    8'h04
`define SUB_INPUT_GAIN     8'h05
// ****************************************
// Reset values
// ****************************************
`define RST_PICTURE_OUTPUT 8'h00
`define RST_CONTROL_ONE    8'h00
`define RST_CONTROL_TWO    8'h00
`define RST_INPUT_GAIN     8'h15
// ****************************************
// Field positions
// ****************************************
`define F1_SPLIT_SEL       0
`define F1_CORING_LO       3
`define F1_CORING_HI       4
`define F1_TRANS_SPEED     5
`define F2_AGC_EN          0
`define F2_ACC_EN          1
`define FO_SIZE_LO         0
`define FO_SIZE_HI         2
// ****************************************
// Output size codes
// ****************************************
`define SIZE_QVGA          3'h0
`define SIZE_VGA           3'h1
`define SIZE_CIF           3'h2
`define SIZE_QCIF          3'h3
`define SIZE_RQVGA         3'h4
`define SIZE_RCIF          3'h5
`define SIZE_601           3'h6
// ****************************************
// Gain loop and levels
// ****************************************
`define GAIN_MAX           7'h78
`define SYNC_SLICE         10'h080
`define SYNC_TARGET_NTSC   10'h0B6
`define SYNC_TARGET_PAL    10'h0C0
`define PEAK_LIMIT         10'h3F0
`define BURST_TARGET_NTSC  10'h0B6
`define BURST_TARGET_PAL   10'h0C0
`define ACC_UNITY          8'h10
`define ACC_GAIN_MAX       8'hA0
`define BLACK_CODE         11'h010
`define SLOW_LINES         4'h8
`define FAST_LINES         4'h2
`define EDGE_DROP_PIXELS   16
// ****************************************
// Timing (ns) and clock rate (MHz)
// ****************************************
`define CLK_MHZ            125
`define SYNC_MIN_NS        2000
`define BURST_START_NS     600
`define BURST_END_NS       3000
`define PEDESTAL_NS        4000
`endif

// file: hdl/pin_sync.v
// Three-stage pin synchroniser with agreement filter
module pin_sync
#(
  parameter [0:0] RST_VAL = 1'b1   // Idle level of the pin
)
(
  input  wire ref_clk,   // System clock
  input  wire reset_n,   // Asynchronous reset, active low
  input  wire pin_i,     // Raw pin level
  output reg  level_q    // Filtered level
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // First stage feeds only the second; change taken once stages two and three agree
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      level_q <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end

endmodule

// file: hdl/vdec_gain_mode_ctrl.v
// Gain loop, chroma level control and picture mode control with serial host port
`include "vdec_consts.vh"

module vdec_gain_mode_ctrl
#(
  parameter [6:0] HOST_PORT_ADDR = 7'h21   // Arbitrary value
)
(
  input  wire        ref_clk,          // 125 MHz system clock
  input  wire        reset_n,          // Asynchronous reset, active low
  input  wire        scl_i,            // Serial clock pin level
  input  wire        sda_i,            // Serial data pin level
  output wire        sda_o,            // Serial data drive value
  output wire        sda_oe,           // Serial data output enable
  input  wire [9:0]  adc_sample,       // Digitized composite sample
  input  wire        pal_input,        // Input colour system is PAL
  output reg  [6:0]  pga_gain,         // Amplifier gain, 0.1 dB per code
  output reg         clk_sel_245,      // 1 selects 24.5454 MHz, 0 selects 27 MHz
  output reg  [2:0]  output_size,      // Output size select code
  output reg         crop_edges,       // Drop edge pixels on each side
  output reg         line_rate_double, // Output lines at twice input rate
  output reg         luma_2d,          // Two-dimensional luma separation
  output reg         chroma_2d,        // Two-dimensional chroma separation
  output reg         pal_line_phase_averaging, // Line chroma phase averaging
  output reg         hsync_detect,     // One-cycle pulse at recovered sync end
  output reg  [7:0]  video_out,        // Pedestal-clamped luma, 8-bit scale
  output reg  [7:0]  chroma_gain,      // Chroma level gain, unity 0x10
  output reg         agc_active,       // Gain loop running
  output reg         acc_active        // Chroma level control running
);

  // ****************************************
  // Timing counts
  // ****************************************
  localparam integer SYNC_MIN_CYC  = (`SYNC_MIN_NS * `CLK_MHZ + 999) / 1000;
  localparam integer BURST_ST_CYC  = (`BURST_START_NS * `CLK_MHZ + 999) / 1000;
  localparam integer BURST_END_CYC = (`BURST_END_NS * `CLK_MHZ) / 1000;
  localparam integer PED_CYC       = (`PEDESTAL_NS * `CLK_MHZ + 999) / 1000;
  // Register-wide reset value; only the seven gain bits are stored
  localparam [7:0]   GAIN_RST      = `RST_INPUT_GAIN;

  // ****************************************
  // Host port states
  // ****************************************
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_ADDR  = 4'h1;
  localparam [3:0] ST_AACK  = 4'h2;
  localparam [3:0] ST_SUB   = 4'h3;
  localparam [3:0] ST_SACK  = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WACK  = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK  = 4'h8;

  wire scl_s;
  wire sda_s;
  reg  scl_p_q;
  reg  sda_p_q;
  reg  [3:0] state_q;
  reg  [3:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg  [7:0] sub_q;
  reg  [7:0] tx_q;
  reg        read_q;
  reg        drive_q;
  reg  [7:0] picture_output_q;
  reg  [7:0] control_one_q;
  reg  [7:0] control_two_q;
  reg  [6:0] host_gain_q;
  reg  [6:0] loop_gain_q;
  reg  [7:0] rd_data;

  pin_sync #(.RST_VAL (1'b1)) u_scl_sync
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin_i   (scl_i),
    .level_q (scl_s)
  );

  pin_sync #(.RST_VAL (1'b1)) u_sda_sync
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin_i   (sda_i),
    .level_q (sda_s)
  );

  // Open-drain: only ever pull low
  assign sda_o  = 1'b0;
  assign sda_oe = drive_q;

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  wire agc_en  = control_two_q[`F2_AGC_EN];
  wire acc_en  = control_two_q[`F2_ACC_EN];
  wire split   = control_one_q[`F1_SPLIT_SEL];
  wire [2:0] size_sel = picture_output_q[`FO_SIZE_HI:`FO_SIZE_LO];

  // ****************************************
  // Register read mux
  // ****************************************
  // Unmapped sub-addresses read as zero
  always @*
  begin
    case (sub_q)
      `SUB_PICTURE_OUTPUT: rd_data = picture_output_q;
      `SUB_CONTROL_ONE:    rd_data = control_one_q;
      `SUB_CONTROL_TWO:    rd_data = control_two_q;
      `SUB_INPUT_GAIN:     rd_data = {1'b0, (agc_en ? loop_gain_q : host_gain_q)};
      default:             rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // Serial host port slave
  // ****************************************
  // Sub-address auto-increments after each data byte in either direction
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_p_q          <= 1'b1;
      sda_p_q          <= 1'b1;
      state_q          <= ST_IDLE;
      bit_cnt_q        <= 4'h0;
      shift_q          <= 8'h00;
      sub_q            <= 8'h00;
      tx_q             <= 8'h00;
      read_q           <= 1'b0;
      drive_q          <= 1'b0;
      picture_output_q <= `RST_PICTURE_OUTPUT;
      control_one_q    <= `RST_CONTROL_ONE;
      control_two_q    <= `RST_CONTROL_TWO;
      host_gain_q      <= GAIN_RST[6:0];
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (bus_start)
      begin
        state_q   <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        drive_q   <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_q <= ST_IDLE;
        drive_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_ADDR, ST_SUB, ST_WDATA:
          begin
            if (scl_rise)
            begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              bit_cnt_q <= 4'h0;
              if (state_q == ST_ADDR)
              begin
                if (shift_q[7:1] == HOST_PORT_ADDR)
                begin
                  read_q  <= shift_q[0];
                  drive_q <= 1'b1;
                  state_q <= ST_AACK;
                end
                else
                  state_q <= ST_IDLE;
              end
              else if (state_q == ST_SUB)
              begin
                sub_q   <= shift_q;
                drive_q <= 1'b1;
                state_q <= ST_SACK;
              end
              else
              begin
                // Reserved bits of picture output and control one are stored as zero; control two keeps all eight bits
                case (sub_q)
                  `SUB_PICTURE_OUTPUT: picture_output_q <= {5'h00, shift_q[2:0]};
                  `SUB_CONTROL_ONE:    control_one_q <= {1'b0, shift_q[6:0]};
                  `SUB_CONTROL_TWO:    control_two_q <= shift_q;
                  `SUB_INPUT_GAIN:     host_gain_q <= shift_q[6:0];
                  default:             control_two_q <= control_two_q;
                endcase
                sub_q   <= sub_q + 8'h01;
                drive_q <= 1'b1;
                state_q <= ST_WACK;
              end
            end
          end
          ST_AACK, ST_SACK, ST_WACK:
          begin
            if (scl_fall)
            begin
              if (state_q == ST_AACK && read_q)
              begin
                tx_q    <= {rd_data[6:0], 1'b0};
                drive_q <= ~rd_data[7];
                state_q <= ST_RDATA;
              end
              else
              begin
                drive_q <= 1'b0;
                state_q <= (state_q == ST_AACK) ? ST_SUB : ST_WDATA;
              end
            end
          end
          ST_RDATA:
          begin
            if (scl_rise)
              bit_cnt_q <= bit_cnt_q + 4'h1;
            else if (scl_fall)
            begin
              if (bit_cnt_q == 4'h8)
              begin
                bit_cnt_q <= 4'h0;
                drive_q   <= 1'b0;
                sub_q     <= sub_q + 8'h01;
                state_q   <= ST_RACK;
              end
              else
              begin
                drive_q <= ~tx_q[7];
                tx_q    <= {tx_q[6:0], 1'b0};
              end
            end
          end
          ST_RACK:
          begin
            // A not-acknowledge from the master ends the read
            if (scl_rise && sda_s)
              state_q <= ST_IDLE;
            else if (scl_fall)
            begin
              tx_q    <= {rd_data[6:0], 1'b0};
              drive_q <= ~rd_data[7];
              state_q <= ST_RDATA;
            end
          end
          default:
          begin
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Sync recovery from samples
  // ****************************************
  // Samples arrive on the fixed ref_clk; nothing here locks to the video
  reg  [11:0] low_cnt_q;
  reg  [11:0] post_cnt_q;
  reg         in_sync_q;
  reg  [9:0]  tip_q;
  reg  [9:0]  pedestal_q;
  reg  [9:0]  sync_height_q;
  reg  [9:0]  burst_max_q;
  reg  [9:0]  burst_min_q;
  reg  [9:0]  burst_amp_q;
  reg  [9:0]  line_peak_q;
  reg         line_done_q;
  wire        below = adc_sample < `SYNC_SLICE;

  // Width qualification rejects short noise dips below the slice level
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_cnt_q     <= 12'h000;
      post_cnt_q    <= 12'hFFF;
      in_sync_q     <= 1'b0;
      tip_q         <= 10'h3FF;
      pedestal_q    <= 10'h000;
      sync_height_q <= 10'h000;
      burst_max_q   <= 10'h000;
      burst_min_q   <= 10'h3FF;
      burst_amp_q   <= 10'h000;
      line_peak_q   <= 10'h000;
      line_done_q   <= 1'b0;
      hsync_detect  <= 1'b0;
    end
    else
    begin
      hsync_detect <= 1'b0;
      line_done_q  <= 1'b0;
      if (below)
      begin
        low_cnt_q <= (low_cnt_q == 12'hFFF) ? low_cnt_q : low_cnt_q + 12'h001;
        if (low_cnt_q == SYNC_MIN_CYC)
        begin
          in_sync_q <= 1'b1;
          tip_q     <= adc_sample;
        end
        else if (in_sync_q && adc_sample < tip_q)
          tip_q <= adc_sample;
      end
      else
      begin
        low_cnt_q <= 12'h000;
        if (in_sync_q)
        begin
          in_sync_q    <= 1'b0;
          hsync_detect <= 1'b1;
          post_cnt_q   <= 12'h000;
          burst_max_q  <= 10'h000;
          burst_min_q  <= 10'h3FF;
        end
        else if (post_cnt_q != 12'hFFF)
          post_cnt_q <= post_cnt_q + 12'h001;
      end
      if (post_cnt_q >= BURST_ST_CYC && post_cnt_q <= BURST_END_CYC)
      begin
        if (adc_sample > burst_max_q)
          burst_max_q <= adc_sample;
        if (adc_sample < burst_min_q)
          burst_min_q <= adc_sample;
      end
      if (post_cnt_q == PED_CYC)
      begin
        pedestal_q    <= adc_sample;
        sync_height_q <= (adc_sample > tip_q) ? adc_sample - tip_q : 10'h000;
        burst_amp_q   <= (burst_max_q > burst_min_q) ? burst_max_q - burst_min_q : 10'h000;
        line_done_q   <= 1'b1;
      end
      // Peak tracked over the active line, restarted each line
      if (line_done_q)
        line_peak_q <= 10'h000;
      else if (adc_sample > line_peak_q)
        line_peak_q <= adc_sample;
    end
  end

  // ****************************************
  // Gain loop
  // ****************************************
  reg  [3:0]  line_cnt_q;
  wire [9:0]  sync_target = pal_input ? `SYNC_TARGET_PAL : `SYNC_TARGET_NTSC;
  wire [9:0]  err_mag = (sync_height_q > sync_target) ? sync_height_q - sync_target
                                                      : sync_target - sync_height_q;
  wire [3:0]  interval = control_one_q[`F1_TRANS_SPEED] ? `FAST_LINES : `SLOW_LINES;
  reg  [9:0]  core_band;
  reg         core_off;

  // Dead band from the coring field
  always @*
  begin
    core_off = 1'b0;
    case (control_one_q[`F1_CORING_HI:`F1_CORING_LO])
      2'h0:    core_band = 10'h002;
      2'h1:    core_band = 10'h003;
      2'h2:    core_band = 10'h004;
      default:
      begin
        core_band = 10'h000;
        core_off  = 1'b1;
      end
    endcase
  end

  // Peak overload cuts gain at once; sync-based correction paces at the interval
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loop_gain_q <= GAIN_RST[6:0];
      line_cnt_q  <= 4'h0;
    end
    else if (!agc_en)
    begin
      loop_gain_q <= host_gain_q;
      line_cnt_q  <= 4'h0;
    end
    else if (line_done_q)
    begin
      if (line_peak_q >= `PEAK_LIMIT)
      begin
        if (loop_gain_q != 7'h00)
          loop_gain_q <= loop_gain_q - 7'h01;
        line_cnt_q <= 4'h0;
      end
      else if (line_cnt_q + 4'h1 >= interval)
      begin
        line_cnt_q <= 4'h0;
        if (core_off || err_mag > core_band)
        begin
          if (sync_height_q > sync_target && loop_gain_q != 7'h00)
            loop_gain_q <= loop_gain_q - 7'h01;
          else if (sync_height_q < sync_target && loop_gain_q < `GAIN_MAX)
            loop_gain_q <= loop_gain_q + 7'h01;
        end
      end
      else
        line_cnt_q <= line_cnt_q + 4'h1;
    end
  end

  // ****************************************
  // Chroma level control
  // ****************************************
  // Saturation stage downstream multiplies the normalized chroma separately
  wire [9:0]  burst_target = pal_input ? `BURST_TARGET_PAL : `BURST_TARGET_NTSC;
  wire [17:0] burst_scaled = {8'h00, burst_amp_q} * {10'h000, chroma_gain};
  wire [9:0]  burst_out = burst_scaled[13:4];
  wire        burst_ovf = |burst_scaled[17:14];

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      chroma_gain <= `ACC_UNITY;
    else if (!acc_en)
      chroma_gain <= `ACC_UNITY;
    else if (line_done_q && burst_amp_q != 10'h000)
    begin
      if (burst_ovf || burst_out > burst_target)
      begin
        if (chroma_gain != 8'h01)
          chroma_gain <= chroma_gain - 8'h01;
      end
      else if (burst_out < burst_target && chroma_gain < `ACC_GAIN_MAX)
        chroma_gain <= chroma_gain + 8'h01;
    end
  end

  // ****************************************
  // Pedestal clamp and mode outputs
  // ****************************************
  // Offset removal in samples keeps black at the same code for either sync level
  wire signed [10:0] ped_diff = $signed({1'b0, adc_sample}) - $signed({1'b0, pedestal_q});
  wire signed [10:0] ped_lvl  = (ped_diff >>> 2) + $signed(`BLACK_CODE);

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      video_out                <= 8'h00;
      pga_gain                 <= GAIN_RST[6:0];
      clk_sel_245              <= 1'b1;
      output_size              <= `SIZE_QVGA;
      crop_edges               <= 1'b0;
      line_rate_double         <= 1'b0;
      luma_2d                  <= 1'b0;
      chroma_2d                <= 1'b0;
      pal_line_phase_averaging <= 1'b0;
      agc_active               <= 1'b0;
      acc_active               <= 1'b0;
    end
    else
    begin
      if (ped_lvl < 11'sd0)
        video_out <= 8'h00;
      else if (ped_lvl > 11'sd255)
        video_out <= 8'hFF;
      else
        video_out <= ped_lvl[7:0];
      pga_gain    <= agc_en ? loop_gain_q : host_gain_q;
      agc_active  <= agc_en;
      acc_active  <= acc_en;
      output_size <= size_sel;
      clk_sel_245 <= (size_sel == `SIZE_VGA) || (size_sel == `SIZE_QVGA) ||
                     (size_sel == `SIZE_RQVGA) || (size_sel == `SIZE_RCIF);
      crop_edges  <= (size_sel == `SIZE_RCIF);
      line_rate_double <= (size_sel == `SIZE_CIF) && !pal_input;
      luma_2d     <= !pal_input && split &&
                     ((size_sel == `SIZE_VGA) || (size_sel == `SIZE_601));
      chroma_2d   <= !pal_input && split && (size_sel != `SIZE_CIF);
      pal_line_phase_averaging <= pal_input && split && (size_sel != `SIZE_VGA);
    end
  end

endmodule

// file: verif/vdec_gain_mode_ctrl_checker.sv
// Port assertions for the gain and mode control block
module vdec_gain_mode_ctrl_checker
(
  input wire       ref_clk,     // Clock
  input wire       reset_n,     // Reset, active low
  input wire       pal_input,   // PAL input
  input wire [2:0] output_size, // Size code
  input wire [6:0] pga_gain,    // Applied gain
  input wire       clk_sel_245, // Clock choice
  input wire       crop_edges,  // Edge drop
  input wire       line_rate_double, // Double rate
  input wire       luma_2d,     // 2D luma
  input wire       chroma_2d,   // 2D chroma
  input wire       pal_line_phase_averaging, // Averaging
  input wire       hsync_detect, // Sync pulse
  input wire [7:0] chroma_gain, // Chroma gain
  input wire       agc_active,  // Gain loop on
  input wire       acc_active   // Chroma loop on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Mode decoding, judged once size and colour system settle
  // ****************************************
  sequence s_held;
    $stable(output_size) && $stable(pal_input) ##1 $stable(output_size) && $stable(pal_input);
  endsequence
  sequence s_acc_off;
    !acc_active ##1 !acc_active;
  endsequence
  a_clock_by_size: assert property (s_held |-> clk_sel_245 == (output_size inside {0, 1, 4, 5}))
    else $error("clock choice wrong for size");
  a_crop_rot_cif: assert property (s_held |-> crop_edges == (output_size == 3'h5))
    else $error("edge drop wrong for size");
  a_double_cif: assert property (s_held |-> line_rate_double == (output_size == 3'h2 && !pal_input))
    else $error("line rate wrong");
  a_luma_two_d: assert property (s_held ##0 luma_2d |-> !pal_input && output_size inside {1, 6})
    else $error("2D luma outside VGA or 601");
  a_chroma_two_d: assert property (s_held ##0 chroma_2d |-> !pal_input && output_size != 3'h2)
    else $error("2D chroma in CIF or PAL");
  a_pal_avg_vga: assert property (s_held ##0 pal_line_phase_averaging |-> pal_input && output_size != 3'h1)
    else $error("averaging on in VGA or NTSC");
  // ****************************************
  // Loop limits and sync pulse width
  // ****************************************
  a_acc_unity: assert property (s_acc_off |-> chroma_gain == 8'h10)
    else $error("chroma gain not unity with loop off");
  a_acc_range: assert property (chroma_gain >= 8'h01 && chroma_gain <= 8'hA0)
    else $error("chroma gain beyond 20 dB");
  a_gain_ceiling: assert property (agc_active ##1 agc_active |-> pga_gain <= 7'h78)
    else $error("loop gain beyond 12 dB");
  a_sync_pulse: assert property (hsync_detect |=> !hsync_detect)
    else $error("sync pulse longer than one cycle");
endmodule

// file: verif/tb_vdec_gain_mode_ctrl.sv
// Self-checking bench for the gain and mode control block
module tb_vdec_gain_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [6:0] A = 7'h21; // Arbitrary host port address
  reg        ref_clk, reset_n, scl_m, sda_m, pal, ack, seen;
  reg  [9:0] adc;
  reg  [7:0] v, e;
  wire       sda_o, sda_oe, clk_sel_245, crop_edges, line_rate_double, luma_2d, chroma_2d;
  wire       pal_line_phase_averaging, hsync_detect, agc_active, acc_active;
  wire [6:0] pga_gain;
  wire [2:0] output_size;
  wire [7:0] video_out, chroma_gain;
  // Open drain line with pull-up
  wire       sda_ln = sda_oe ? sda_o : sda_m;
  integer    mismatches, num_checks, s, p, k;
  vdec_gain_mode_ctrl #(.HOST_PORT_ADDR(A)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .scl_i(scl_m), .sda_i(sda_ln), .sda_o(sda_o), .sda_oe(sda_oe), .adc_sample(adc),
    .pal_input(pal), .pga_gain(pga_gain), .clk_sel_245(clk_sel_245),
    .output_size(output_size), .crop_edges(crop_edges), .line_rate_double(line_rate_double),
    .luma_2d(luma_2d), .chroma_2d(chroma_2d),
    .pal_line_phase_averaging(pal_line_phase_averaging), .hsync_detect(hsync_detect),
    .video_out(video_out), .chroma_gain(chroma_gain), .agc_active(agc_active),
    .acc_active(acc_active));
  // ****************************************
  // Serial host port tasks; phases of 8 cycles clear the pin filter
  // ****************************************
  task hp;
    repeat (8) @(negedge ref_clk);
  endtask
  task bit_io(input b, output r);
    sda_m = b; hp; scl_m = 1'b1; hp; r = sda_ln; scl_m = 1'b0; hp;
  endtask
  task start;
    sda_m = 1'b1; hp; scl_m = 1'b1; hp; sda_m = 1'b0; hp; scl_m = 1'b0; hp;
  endtask
  task stop;
    sda_m = 1'b0; hp; scl_m = 1'b1; hp; sda_m = 1'b1; hp;
  endtask
  task tx(input [7:0] d);
    for (k = 7; k >= 0; k--) bit_io(d[k], ack);
    bit_io(1'b1, ack);
    chk("ack", 8'h00, {7'h0, ack});
  endtask
  task wr(input [7:0] sub, input [7:0] d);
    start; tx({A, 1'b0}); tx(sub); tx(d); stop; repeat (4) @(negedge ref_clk);
  endtask
  // Read one register and end with a NACK
  task rd(input [7:0] sub, input [7:0] x);
    start; tx({A, 1'b0}); tx(sub); start; tx({A, 1'b1});
    for (k = 7; k >= 0; k--) bit_io(1'b1, v[k]);
    bit_io(1'b1, ack); stop;
    chk("register", x, v);
  endtask
  // One video line: sync tip, then a burst of height b on the blanking level
  task line(input [9:0] b);
    adc = 10'h040;
    repeat (300) @(negedge ref_clk);
    adc = 10'h100;
    seen = 1'b0;
    for (k = 0; k < 20 && !seen; k++)
    begin
      @(negedge ref_clk);
      seen = (hsync_detect === 1'b1);
    end
    chk("sync seen", 8'h01, {7'h0, seen});
    repeat (80) @(negedge ref_clk);
    adc = 10'h100 + b;
    repeat (100) @(negedge ref_clk);
    adc = 10'h100;
    repeat (420) @(negedge ref_clk);
  endtask
  task chk(input string n, input [7:0] x, input [7:0] g);
    num_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task results;
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // Clock, reset and scenarios
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    mismatches = 0; num_checks = 0; reset_n = 1'b0; scl_m = 1'b1; sda_m = 1'b1;
    pal = 1'b0; adc = 10'h100;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    chk("reset gain", 8'h15, {1'b0, pga_gain});
    rd(8'h03, 8'h00); rd(8'h04, 8'h00); rd(8'h05, 8'h15); rd(8'h07, 8'h00);
    wr(8'h05, 8'h30);
    chk("manual gain", 8'h30, {1'b0, pga_gain});
    wr(8'h04, 8'h01);
    chk("loop on", 8'h01, {7'h0, agc_active});
    wr(8'h05, 8'h50);
    chk("write held", 8'h30, {1'b0, pga_gain});
    rd(8'h05, 8'h30);
    wr(8'h04, 8'h00);
    chk("host gain back", 8'h50, {1'b0, pga_gain});
    rd(8'h05, 8'h50);
    wr(8'h04, 8'h03);
    chk("both loops", 8'h03, {6'h0, acc_active, agc_active});
    // Size and filter decoding for each colour system and split choice
    for (p = 0; p < 4; p++)
    begin
      wr(8'h03, p[1]);
      pal = p[0];
      for (s = 0; s < 7; s++)
      begin
        wr(8'h01, s);
        e = {2'b0, s inside {0, 1, 4, 5}, s == 5, s == 2 && !p[0], !p[0] && p[1] && s inside {1, 6},
          !p[0] && p[1] && s != 2, p[0] && p[1] && s != 1};
        chk("size", s, {5'h0, output_size});
        chk("modes", e, {2'b0, clk_sel_245, crop_edges, line_rate_double, luma_2d, chroma_2d,
          pal_line_phase_averaging});
      end
    end
    // Fast transition, NTSC: sync height 0xC0 above target, burst 0x40 below target
    pal = 1'b0;
    wr(8'h03, 8'h20);
    line(10'h040);
    line(10'h040);
    rd(8'h05, 8'h4F);
    chk("loop gain", 8'h4F, {1'b0, pga_gain});
    chk("chroma gain", 8'h12, chroma_gain);
    chk("black level", 8'h10, video_out);
    results;
  end
endmodule
bind vdec_gain_mode_ctrl vdec_gain_mode_ctrl_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .pal_input(pal_input), .output_size(output_size), .pga_gain(pga_gain),
  .clk_sel_245(clk_sel_245), .crop_edges(crop_edges), .line_rate_double(line_rate_double),
  .luma_2d(luma_2d), .chroma_2d(chroma_2d), .hsync_detect(hsync_detect),
  .pal_line_phase_averaging(pal_line_phase_averaging), .chroma_gain(chroma_gain),
  .agc_active(agc_active), .acc_active(acc_active));
